// File: design/psa_sram.sv
// Purpose: synchronous access logic of a pipelined double-cycle-deselect burst SRAM
// Assumes: all inputs synchronous to clock_i; output enable sampled like the rest
// Notes:   array is flip-flops indexed by the low MEM_AW address bits
//
// Function
// - Strap low linear, high interleaved order
// - Test data out changes on TCK fall
// - TDI and TMS sampled on TCK rise
// - Inputs and read data registered on clock
// - Two-bit wraparound counter supplies burst addresses
// - Global write writes all bytes
// - Processor strobe ignored when first enable high
// - Read starts on strobe, selected, no write
// - Read data appears after next clock rise
// - Tristated first cycle leaving deselect
// - Deselect drives one more clock, then tristates
// - Processor strobe first cycle ignores write, advance
// - Processor write completes at second rise
// - Unselected bytes stay unchanged
// - Drivers off whenever a write detected
// - Controller write completes in one clock
// - Advance low steps burst counter
// - Counter seeded from address bits 1:0
// - Interleaved order is start XOR beat
// - Linear order is start plus beat
// - Both strobes low: processor strobe wins
// - Chip enables sampled only on loads
`include "psa_map.svh"

module psa_sram #(
  parameter int ADDR_W = `PSA_ADDR_W,
  parameter int MEM_AW = `PSA_MEM_AW,
  parameter int BYTES  = `PSA_BYTES,
  parameter int BYTE_W = `PSA_BYTE_W
) (
  // Clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      resetn_i,
  // Address and strobes
  input  wire logic [ADDR_W-1:0]         address_i,
  input  wire logic                      proc_addr_strobe_n_i,
  input  wire logic                      ctrl_addr_strobe_n_i,
  input  wire logic                      burst_advance_n_i,
  // Chip enables
  input  wire logic                      chip_enable_first_n_i,
  input  wire logic                      chip_enable_second_i,
  input  wire logic                      chip_enable_third_n_i,
  // Write controls
  input  wire logic                      global_write_n_i,
  input  wire logic                      byte_write_enable_n_i,
  input  wire logic [BYTES-1:0]          byte_write_select_n_i,
  // Output enable and burst order strap
  input  wire logic                      output_enable_n_i,
  input  wire logic                      mode_i,
  // Data and parity lines, byte b holds parity_data_lines in its top bit
  input  wire logic [BYTES*BYTE_W-1:0]   dq_i,
  output logic      [BYTES*BYTE_W-1:0]   dq_o,
  output logic      [BYTES*BYTE_W-1:0]   dq_oe_o,
  // Boundary-scan pins
  input  wire logic                      tck_i,
  input  wire logic                      tms_i,
  input  wire logic                      tdi_i,
  output logic                           tdo_o
);

  localparam int DW    = BYTES * BYTE_W;
  localparam int DEPTH = 2 ** MEM_AW;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [ADDR_W-1:0]        addr;
    psa_pkg::psa_beat_t       start;
    psa_pkg::psa_beat_t       beat;
    logic                     act;
    logic                     pfirst;
    logic [DW-1:0]            dq;
    logic [DW-1:0]            dq_oe;
    psa_pkg::psa_order_e      order;
    logic                     strap_done;
    logic                     tck_q;
    logic                     tdi_cap;
    logic                     tms_cap;
    logic                     tdo;
  } psa_state_s;

  psa_state_s st_reg;
  psa_state_s st_next;
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // Burst address for a given beat
  function automatic psa_pkg::psa_beat_t burst_addr(
    input psa_pkg::psa_beat_t  start,
    input psa_pkg::psa_beat_t  beat,
    input psa_pkg::psa_order_e order
  );
    if (order == psa_pkg::PSA_LINEAR) begin
      burst_addr = psa_pkg::psa_beat_t'(start + beat);
    end else begin
      burst_addr = start ^ beat;
    end
  endfunction : burst_addr

  // Reset release through two flops
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  logic                     ce_ok;
  logic                     proc_addr_strobe_n_go;
  logic                     ctrl_addr_strobe_n_go;
  logic                     load;
  logic                     cont;
  logic [BYTES-1:0]         mask;
  logic                     wr_req;
  logic                     ctrl_addr_strobe_n_wr;
  logic                     cont_wr;
  logic                     step;
  logic                     drive;
  psa_pkg::psa_beat_t       beat_nx;
  logic [ADDR_W-1:0]        cur_addr;
  logic [ADDR_W-1:0]        wr_addr;
  logic [BYTES-1:0]         wr_mask;
  logic [MEM_AW-1:0]        wr_idx;

  always_comb begin
    st_next = st_reg;

    // Strap caught once after reset release; changes later are not seen
    if (!st_reg.strap_done) begin
      st_next.order      = mode_i ? psa_pkg::PSA_INTERLEAVED : psa_pkg::PSA_LINEAR;
      st_next.strap_done = 1'b1;
    end

    ce_ok   = ~chip_enable_first_n_i & chip_enable_second_i & ~chip_enable_third_n_i;
    proc_addr_strobe_n_go = ~proc_addr_strobe_n_i & ~chip_enable_first_n_i;
    ctrl_addr_strobe_n_go = ~ctrl_addr_strobe_n_i & ~proc_addr_strobe_n_go;
    load    = proc_addr_strobe_n_go | ctrl_addr_strobe_n_go;
    cont    = st_reg.act & ~load;

    // Global write overrides the byte controls
    if (!global_write_n_i) begin
      mask = {BYTES{1'b1}};
    end else if (!byte_write_enable_n_i) begin
      mask = ~byte_write_select_n_i;
    end else begin
      mask = '0;
    end
    wr_req  = |mask;
    ctrl_addr_strobe_n_wr = ctrl_addr_strobe_n_go & ce_ok & wr_req;
    cont_wr = cont & wr_req;

    step    = cont & ~burst_advance_n_i;
    beat_nx = step ? psa_pkg::psa_beat_t'(st_reg.beat + `PSA_BEAT_ONE) : st_reg.beat;
    cur_addr = {st_reg.addr[ADDR_W-1:`PSA_CNT_W],
                burst_addr(st_reg.start, st_reg.beat, st_reg.order)};

    // Read path: array word into the output register, shown after this rise
    drive = st_reg.act & ~cont_wr & ~ctrl_addr_strobe_n_wr;
    if (drive) begin
      st_next.dq = st_reg.mem[cur_addr[MEM_AW-1:0]];
    end
    // Deselected or fresh-from-deselect cycles leave act low, so no drive
    st_next.dq_oe = {DW{drive & ~output_enable_n_i}};

    // Write path; a burst write beat lands on the advanced address, the first beat after a processor strobe on the current one
    wr_addr = address_i;
    wr_mask = '0;
    if (ctrl_addr_strobe_n_wr) begin
      wr_mask = mask;
    end else if (cont_wr) begin
      wr_mask = mask;
      if (!st_reg.pfirst) begin
        wr_addr = {st_reg.addr[ADDR_W-1:`PSA_CNT_W],
                   burst_addr(st_reg.start, beat_nx, st_reg.order)};
      end else begin
        wr_addr = cur_addr;
      end
    end
    wr_idx = wr_addr[MEM_AW-1:0];
    for (int b = 0; b < BYTES; b++) begin
      if (wr_mask[b]) begin
        st_next.mem[wr_idx][b*BYTE_W +: BYTE_W] = dq_i[b*BYTE_W +: BYTE_W];
      end
    end

    // Address register and burst counter
    if (load) begin
      if (ce_ok) begin
        st_next.addr   = address_i;
        st_next.start  = address_i[`PSA_CNT_W-1:0];
        st_next.beat   = `PSA_BEAT_RST;
        st_next.act    = 1'b1;
        st_next.pfirst = proc_addr_strobe_n_go;
      end else begin
        st_next.act    = 1'b0;
        st_next.pfirst = 1'b0;
      end
    end else begin
      st_next.beat   = beat_nx;
      st_next.pfirst = 1'b0;
    end

    // Boundary scan: bypass bit, shifted while TMS is low
    st_next.tck_q = tck_i;
    if (tck_i && !st_reg.tck_q) begin
      st_next.tdi_cap = tdi_i;
      st_next.tms_cap = tms_i;
    end
    if (!tck_i && st_reg.tck_q && !st_reg.tms_cap) begin
      st_next.tdo = st_reg.tdi_cap;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dq_o    = st_reg.dq;
  assign dq_oe_o = st_reg.dq_oe;
  assign tdo_o   = st_reg.tdo;

endmodule : psa_sram

// File: design/psa_map.svh
// Purpose: constants for the pipelined sync SRAM access block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef PSA_MAP_SVH
`define PSA_MAP_SVH

// Address and data geometry
`define PSA_ADDR_W   18
`define PSA_MEM_AW   6
`define PSA_BYTES    4
`define PSA_BYTE_W   9

// Burst counter
`define PSA_CNT_W    2
`define PSA_BEAT_RST 2'h0
`define PSA_BEAT_ONE 2'h1

// Clock period in ns
`define PSA_CLK_NS   100

`endif

// File: design/psa_pkg.sv
// Purpose: shared types of the pipelined sync SRAM access block
// Assumes: psa_map.svh supplies the widths
// Notes:   types only; constants live in the map header
`include "psa_map.svh"

package psa_pkg;

  typedef enum logic {
    PSA_LINEAR,
    PSA_INTERLEAVED
  } psa_order_e;

  typedef logic [`PSA_CNT_W-1:0] psa_beat_t;

endpackage : psa_pkg

// File: dv/psa_sram_props.sv
// Purpose: port checks of psa_sram
// Assumes: bound to psa_sram
// Notes:   drive enable judged on bit 0
module psa_sram_props (
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic        proc_addr_strobe_n_i,
  input wire logic        ctrl_addr_strobe_n_i,
  input wire logic        chip_enable_first_n_i,
  input wire logic        chip_enable_second_i,
  input wire logic        chip_enable_third_n_i,
  input wire logic        global_write_n_i,
  input wire logic        byte_write_enable_n_i,
  input wire logic        output_enable_n_i,
  input wire logic [35:0] dq_oe_o,
  input wire logic        tdo_o
);
  wire sel = !chip_enable_first_n_i && chip_enable_second_i && !chip_enable_third_n_i;
  wire pld = !proc_addr_strobe_n_i && !chip_enable_first_n_i;
  wire ld  = pld || !ctrl_addr_strobe_n_i;
  wire rdc = global_write_n_i && byte_write_enable_n_i;
  wire drv = dq_oe_o[0];
  logic on_reg;
  // Selection at last load, needed to spot leaving deselect
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) on_reg <= 1'b0;
    else if (ld) on_reg <= sel;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rd_load; ld && sel && rdc; endsequence
  sequence s_desel; ld && !sel; endsequence
  a_ctrl_wr_off: assert property (!ctrl_addr_strobe_n_i && !pld && sel && !global_write_n_i
    |=> !drv) else $error("drive after controller write");
  a_proc_wr_off: assert property ((pld && sel) ##1 (!global_write_n_i && !ld)
    |=> !drv) else $error("drive after processor write");
  a_first_tristate: assert property (ld && sel && rdc && !on_reg
    |=> !drv) else $error("drive in first read cycle");
  a_read_drive: assert property (s_rd_load ##1 (!output_enable_n_i && rdc)
    |=> drv) else $error("read data not driven");
  a_desel_hold: assert property (s_desel and (drv && on_reg && !output_enable_n_i)
    |=> drv) else $error("deselect dropped drive early");
  a_desel_off: assert property (s_desel ##1 !ld |=> !drv) else $error("deselect kept drive");
  a_oe_off: assert property (output_enable_n_i |=> !drv) else $error("drive with OE high");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |-> !dq_oe_o && !tdo_o)
    else $error("outputs active in reset");
endmodule : psa_sram_props

bind psa_sram psa_sram_props u_props (.clock_i, .resetn_i, .proc_addr_strobe_n_i,
  .ctrl_addr_strobe_n_i, .chip_enable_first_n_i, .chip_enable_second_i,
  .chip_enable_third_n_i, .global_write_n_i, .byte_write_enable_n_i,
  .output_enable_n_i, .dq_oe_o, .tdo_o);

// File: dv/psa_host.sv
// Purpose: host side of the shared data lines
// Assumes: host drives only while host_en_i is high
// Notes:   released lines show the inverse of their last level
module psa_host (
  input  wire logic        clock_i,
  input  wire logic        host_en_i,
  input  wire logic [35:0] host_d_i,
  input  wire logic [35:0] dq_o,
  input  wire logic [35:0] dq_oe_o,
  output logic      [35:0] dq_i
);
  logic [35:0] last_reg;
  always_ff @(posedge clock_i) last_reg <= dq_i;
  // Stale data must never read as fresh
  always_comb dq_i = host_en_i ? host_d_i : (dq_oe_o & dq_o) | (~dq_oe_o & ~last_reg);
endmodule : psa_host

// File: dv/tb_pipelined_sync_sram_access.sv
// Purpose: self-checking bench of psa_sram
// Assumes: fixed-cycle timing of the bus
// Notes:   both burst orders, one reset each
module tb_pipelined_sync_sram_access;
  timeunit 1ns;
  timeprecision 1ns;
  logic ck = 0, rn = 1, ps = 1, cs = 1, av = 1, c2 = 1, gw = 1, be = 1, oe = 0, md = 0, he = 0;
  logic tk = 0, tm = 0, ti = 0, td;
  logic [3:0] bs = 4'hF;
  logic [17:0] ad = 18'h0;
  logic [35:0] hd = 36'h0, dq_in, dq_out, dq_en;
  logic [35:0] mem [4];
  int err_total = 0, checked = 0;
  always #50 ck = ~ck;
  psa_sram dut (.clock_i(ck), .resetn_i(rn), .address_i(ad), .proc_addr_strobe_n_i(ps),
    .ctrl_addr_strobe_n_i(cs), .burst_advance_n_i(av), .chip_enable_first_n_i(1'b0),
    .chip_enable_second_i(c2), .chip_enable_third_n_i(1'b0), .global_write_n_i(gw),
    .byte_write_enable_n_i(be), .byte_write_select_n_i(bs), .output_enable_n_i(oe),
    .mode_i(md), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_en), .tck_i(tk),
    .tms_i(tm), .tdi_i(ti), .tdo_o(td));
  psa_host u_host (.clock_i(ck), .host_en_i(he), .host_d_i(hd), .dq_o(dq_out),
    .dq_oe_o(dq_en), .dq_i(dq_in));
  task end_of_test;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task cyc;
    @(posedge ck);
    #10;
  endtask : cyc
  task chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Upper bits set so a carry out of the counter lands on unwritten words
  task wr(input int a, input logic [35:0] d);
    ad = 18'h3FFF0 | a; cs = 0; gw = 0; oe = 1; he = 1; hd = d;
    cyc();
    cs = 1; gw = 1; he = 0;
  endtask : wr
  task pwr;
    ad = 18'h3FFF1; ps = 0; cs = 0; gw = 0; hd = 36'h0; he = 1; oe = 1;
    cyc();
    ps = 1; cs = 1; gw = 1; be = 0; bs = 4'hA;
    cyc();
    be = 1; bs = 4'hF; he = 0;
  endtask : pwr
  task rd(input int s, input logic m);
    int w;
    ad = 18'h3FFF0 | s; ps = 0; oe = 0;
    cyc();
    ps = 1; av = 0;
    cyc();
    for (int b = 0; b < 4; b++) begin
      w = m ? (s ^ b) : ((s + b) % 4);
      chk(dq_out, mem[w]);
      chk(dq_en, 36'hFFFFFFFFF);
      cyc();
    end
    av = 1; cs = 0; c2 = 0;
    cyc();
    chk(dq_en, 36'hFFFFFFFFF);
    cs = 1; c2 = 1;
    cyc();
    chk(dq_en, 36'h0);
  endtask : rd
  // Test clock rises then falls; output may only follow on the fall
  task scan;
    ti = 1; tm = 0; tk = 1;
    cyc();
    chk({35'h0, td}, 36'h0);
    tk = 0;
    cyc();
    chk({35'h0, td}, 36'h1);
  endtask : scan
  task run_order(input logic m);
    rn = 0; md = m;
    repeat (10) cyc();
    rn = 1;
    repeat (3) cyc();
    for (int i = 0; i < 4; i++) begin
      mem[i] = 36'h123456780 + i;
      wr(i, mem[i]);
    end
    pwr();
    mem[1] = mem[1] & ~36'h007FC01FF;
    rd(1, m);
    rd(3, m);
    scan();
  endtask : run_order
  initial begin
    repeat (3000) @(posedge ck);
    err_total++;
    end_of_test();
  end
  initial begin
    // Reset edge off the clock so every flop but the host last_reg starts known
    #10;
    run_order(1'b0);
    run_order(1'b1);
    end_of_test();
  end
endmodule : tb_pipelined_sync_sram_access
